// *** shared/shp_cfg.svh ***
// constants for the slave fifo host port: offsets, fields, reset values, timing
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH

// fifo select codes and fifo geometry
`define SHP_SEL_CMD      3'h4
`define SHP_FIFO_DEPTH   4'h8

// polarity_config bit positions, set bit means the signal is active high
`define SHP_POL_WR       2
`define SHP_POL_RD       3
`define SHP_POL_OE       4
`define SHP_POL_PKT      5
`define SHP_POL_RST      8'h00

// device register offsets (wishbone byte addresses)
`define SHP_DEV_CTRL     8'h00
`define SHP_DEV_IRQ_ST   8'h04
`define SHP_DEV_IRQ_MASK 8'h08
`define SHP_DEV_CMD      8'h0c
`define SHP_DEV_LEVELS   8'h10
`define SHP_PF_LEVEL_RST 4'h4

// device interrupt bit positions
`define SHP_IRQ_CMD      0
`define SHP_IRQ_PKT      1
`define SHP_IRQ_OVF      2

// host register offsets
`define SHP_HOST_CTRL    8'h00
`define SHP_HOST_REQ     8'h04
`define SHP_HOST_STATUS  8'h08

// host pin sequencing, in clk_i cycles
`define SHP_SETUP_CYC    4'h3
`define SHP_STROBE_CYC   4'h4
`define SHP_TURN_CYC     4'h8
`define SHP_HOLD_CYC     4'h3

`endif

// *** shared/shp_pkg.sv ***
// types shared by both ends of the slave fifo host port
package shp_pkg;

	typedef enum logic [1:0] {
		SHP_OP_WRITE,
		SHP_OP_READ,
		SHP_OP_COMMIT,
		SHP_OP_NONE
	} shp_op_t;

	typedef enum logic [2:0] {
		SHP_H_IDLE,
		SHP_H_SETUP,
		SHP_H_TURN,
		SHP_H_STROBE,
		SHP_H_HOLD
	} shp_hstate_t;

	typedef struct packed {
		logic [3:0][7:0][15:0] mem;
		logic [3:0][3:0]       cnt;
		logic [3:0][2:0]       wp;
		logic [3:0][2:0]       rp;
		logic                  rd_q;
		logic                  wr_q;
		logic                  pk_q;
		logic [7:0]            pol;
		logic                  status_flag_d_mode;
		logic                  wide;
		logic [1:0]            status_flag_d_sel;
		logic [3:0]            pf_level;
		logic [7:0]            cmd_in;
		logic                  cmd_full;
		logic [7:0]            cmd_out;
		logic [2:0]            last_pkt;
		logic [2:0]            irq_st;
		logic [2:0]            irq_mask;
		logic                  irq;
		logic [15:0]           dq;
		logic [1:0]            dq_oe;
		logic                  fa;
		logic                  fb;
		logic                  fc;
		logic                  fd;
		logic                  fd_oe;
		logic                  ready;
		logic                  ack;
		logic [31:0]           dat;
	} shp_dev_state_t;

	typedef struct packed {
		logic [7:0]  pol;
		logic        wide;
		logic        status_flag_d_mode;
		shp_hstate_t state;
		logic [3:0]  cnt;
		shp_op_t     op;
		logic [15:0] rdat;
		logic [2:0]  sel;
		logic        rd;
		logic        wr;
		logic        oe;
		logic        pkt;
		logic        cs_n;
		logic        cs_oe;
		logic [15:0] dq;
		logic [1:0]  dq_oe;
		logic        ack;
		logic [31:0] dat;
	} shp_host_state_t;

endpackage

// *** shared/shp_link_if.sv ***
// pin-level link between the external master and the fifo device
`timescale 1ns/10ps
interface shp_link_if;
	// master-driven pins
	logic [2:0]  fifo_select;
	logic        fifo_read_strobe;
	logic        fifo_write_strobe;
	logic        fifo_output_enable;
	logic        packet_commit_strobe;
	logic        host_cs_n;
	logic        host_cs_oe;
	logic [15:0] host_dq;
	logic [1:0]  host_dq_oe;
	// device-driven pins
	logic        status_flag_a;
	logic        status_flag_b;
	logic        status_flag_c;
	logic        status_flag_d;
	logic        flag_d_oe;
	logic        ready;
	logic [15:0] dev_dq;
	logic [1:0]  dev_dq_oe;
	// resolved wires, device drive wins, undriven data lanes read low and the undriven shared pin reads high
	logic [15:0] host_data_bus;
	logic        flag_cs_pin;

	assign host_data_bus[7:0]  = dev_dq_oe[0] ? dev_dq[7:0] :
		(host_dq_oe[0] ? host_dq[7:0] : 8'h00);
	assign host_data_bus[15:8] = dev_dq_oe[1] ? dev_dq[15:8] :
		(host_dq_oe[1] ? host_dq[15:8] : 8'h00);
	assign flag_cs_pin = flag_d_oe ? status_flag_d : (host_cs_oe ? host_cs_n : 1'b1);

	modport dev (
		input  fifo_select, fifo_read_strobe, fifo_write_strobe, fifo_output_enable,
		input  packet_commit_strobe, host_data_bus, flag_cs_pin,
		output status_flag_a, status_flag_b, status_flag_c, status_flag_d, flag_d_oe,
		output ready, dev_dq, dev_dq_oe
	);

	modport host (
		output fifo_select, fifo_read_strobe, fifo_write_strobe, fifo_output_enable,
		output packet_commit_strobe, host_cs_n, host_cs_oe, host_dq, host_dq_oe,
		input  status_flag_a, status_flag_b, status_flag_c, flag_cs_pin, ready,
		input  host_data_bus
	);
endinterface // shp_link_if

// *** logic/shp_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module shp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} shp_sync_t;

	shp_sync_t st;
	shp_sync_t next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st    = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;
endmodule // shp_sync

// *** logic/shp_device_end.sv ***
// fifo device end of the slave fifo host port, with a wishbone register slave
//
// Contract
// - select pins choose the addressed fifo
// - packet commit strobe, polarity from bit 5
// - shared pin defaults to active-low chip select
// - flag mode drives a fifo level flag
// - low byte carries fifo and command data
// - upper byte carries fifo data in 16-bit
// - read strobe pops fifo, polarity bit 3
// - write strobe pushes fifo, polarity bit 2
// - flag a shows selected fifo level flag
// - output enable makes device drive, bit 4
// - flag b shows selected fifo full
// - flag c shows selected fifo empty
// - ready gates command reads and writes
`timescale 1ns/10ps
`include "shp_cfg.svh"
module shp_device_end import shp_pkg::*; (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o,
	// link to the master
	shp_link_if.dev          link
);
	shp_dev_state_t st;
	shp_dev_state_t next_st;

	logic [23:0] pin_s;
	logic [2:0]  s_sel;
	logic        s_rd;
	logic        s_wr;
	logic        s_oe;
	logic        s_pkt;
	logic        s_cs;
	logic [15:0] s_dq;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, the master runs from its own clock; control pins are
	// carried inverted so a cleared synchroniser reads as idle high pins and
	// no false strobe edge or bus drive follows reset
	shp_sync #(
		.W(24)
	) u_pin_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({link.fifo_select, ~link.fifo_read_strobe, ~link.fifo_write_strobe,
			~link.fifo_output_enable, ~link.packet_commit_strobe, ~link.flag_cs_pin,
			link.host_data_bus}),
		.q_o   (pin_s)
	);

	// unpack the synchronised pins
	assign s_sel = pin_s[23:21];
	assign s_rd  = ~pin_s[20];
	assign s_wr  = ~pin_s[19];
	assign s_oe  = ~pin_s[18];
	assign s_pkt = ~pin_s[17];
	assign s_cs  = ~pin_s[16];
	assign s_dq  = pin_s[15:0];

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [1:0]  idx;
		logic        is_cmd;
		logic        cs_act;
		logic        rd_act;
		logic        wr_act;
		logic        oe_act;
		logic        pk_act;
		logic        req;
		logic [31:0] wmask;
		logic [2:0]  irq_set;
		logic [2:0]  irq_clr;
		logic [15:0] wr_word;
		logic [15:0] ctrl_new;
		idx      = 2'h0;
		is_cmd   = 1'b0;
		cs_act   = 1'b0;
		rd_act   = 1'b0;
		wr_act   = 1'b0;
		oe_act   = 1'b0;
		pk_act   = 1'b0;
		req      = 1'b0;
		wmask    = '0;
		irq_set  = '0;
		irq_clr  = '0;
		wr_word  = '0;
		ctrl_new = '0;
		next_st  = st;

		// decode the pins against the configured polarity
		idx    = s_sel[1:0];
		is_cmd = (s_sel == `SHP_SEL_CMD);
		cs_act = st.status_flag_d_mode | ~s_cs;
		wr_act = ~(s_wr ^ st.pol[`SHP_POL_WR]);
		rd_act = ~(s_rd ^ st.pol[`SHP_POL_RD]);
		oe_act = ~(s_oe ^ st.pol[`SHP_POL_OE]);
		pk_act = ~(s_pkt ^ st.pol[`SHP_POL_PKT]);
		next_st.wr_q = wr_act;
		next_st.rd_q = rd_act;
		next_st.pk_q = pk_act;

		// wishbone: ack one cycle after the request, write and read side
		// effects at the edge where the master sees ack
		req   = wb_cyc_i & wb_stb_i;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		next_st.ack = req & ~st.ack;
		if (req & ~st.ack) begin
			case (wb_adr_i)
				`SHP_DEV_CTRL: begin
					next_st.dat = {16'h0000, st.pf_level, st.status_flag_d_sel, st.wide,
						st.status_flag_d_mode, st.pol};
				end
				`SHP_DEV_IRQ_ST: begin
					next_st.dat = {29'h0, st.irq_st};
				end
				`SHP_DEV_IRQ_MASK: begin
					next_st.dat = {29'h0, st.irq_mask};
				end
				`SHP_DEV_CMD: begin
					next_st.dat = {23'h0, st.cmd_full, st.cmd_in};
				end
				`SHP_DEV_LEVELS: begin
					next_st.dat = {13'h0, st.last_pkt, st.cnt};
				end
				default: begin
					next_st.dat = 32'h0;
				end
			endcase
		end
		if (req & st.ack & wb_we_i) begin
			case (wb_adr_i)
				`SHP_DEV_CTRL: begin
					ctrl_new = ({st.pf_level, st.status_flag_d_sel, st.wide, st.status_flag_d_mode, st.pol}
						& ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
					next_st.pol        = ctrl_new[7:0];
					next_st.status_flag_d_mode = ctrl_new[8];
					next_st.wide       = ctrl_new[9];
					next_st.status_flag_d_sel  = ctrl_new[11:10];
					next_st.pf_level   = ctrl_new[15:12];
				end
				`SHP_DEV_IRQ_ST: begin
					irq_clr = wb_dat_i[2:0] & wmask[2:0];
				end
				`SHP_DEV_IRQ_MASK: begin
					if (wb_sel_i[0]) begin
						next_st.irq_mask = wb_dat_i[2:0];
					end
				end
				`SHP_DEV_CMD: begin
					if (wb_sel_i[0]) begin
						next_st.cmd_out = wb_dat_i[7:0];
					end
				end
				default: begin
					next_st.irq_mask = st.irq_mask;
				end
			endcase
		end
		// reading the command byte frees the slot and raises ready
		if (req & st.ack & ~wb_we_i & (wb_adr_i == `SHP_DEV_CMD)) begin
			next_st.cmd_full = 1'b0;
		end

		// push on the active edge of the write strobe
		wr_word = st.wide ? s_dq : {8'h00, s_dq[7:0]};
		if (wr_act & ~st.wr_q & cs_act) begin
			if (is_cmd) begin
				// command bytes use the low byte only and need ready high
				if (~st.cmd_full) begin
					next_st.cmd_in   = s_dq[7:0];
					next_st.cmd_full = 1'b1;
					irq_set[`SHP_IRQ_CMD] = 1'b1;
				end
			end else if (st.cnt[idx] == `SHP_FIFO_DEPTH) begin
				irq_set[`SHP_IRQ_OVF] = 1'b1; // a full fifo drops the word
			end else begin
				next_st.mem[idx][st.wp[idx]] = wr_word;
				next_st.wp[idx]  = st.wp[idx] + 3'h1;
				next_st.cnt[idx] = st.cnt[idx] + 4'h1;
			end
		end

		// pop on the active edge of the read strobe; empty reads are ignored
		if (rd_act & ~st.rd_q & cs_act & ~is_cmd & (st.cnt[idx] != 4'h0)) begin
			next_st.rp[idx]  = st.rp[idx] + 3'h1;
			next_st.cnt[idx] = next_st.cnt[idx] - 4'h1;
		end

		// packet commit only flags the event, words are already visible
		if (pk_act & ~st.pk_q & cs_act & ~is_cmd) begin
			next_st.last_pkt = {1'b0, idx};
			irq_set[`SHP_IRQ_PKT] = 1'b1;
		end

		// status flags a to c follow the selected fifo, flag d follows the fifo in status_flag_d_sel
		next_st.fa = (st.cnt[idx] >= st.pf_level);
		next_st.fb = (st.cnt[idx] == `SHP_FIFO_DEPTH);
		next_st.fc = (st.cnt[idx] == 4'h0);
		next_st.fd = (st.cnt[st.status_flag_d_sel] >= st.pf_level);
		next_st.fd_oe = st.status_flag_d_mode;
		next_st.ready = ~next_st.cmd_full;

		// drive the bus only while output enable is active
		next_st.dq_oe[0] = oe_act & cs_act;
		next_st.dq_oe[1] = oe_act & cs_act & st.wide & ~is_cmd;
		if (is_cmd) begin
			next_st.dq = {8'h00, st.cmd_out};
		end else begin
			next_st.dq = st.mem[idx][st.rp[idx]];
		end

		// sticky interrupts, a new event beats a clear in the same cycle
		next_st.irq_st = (st.irq_st & ~irq_clr) | irq_set;
		next_st.irq    = |(next_st.irq_st & next_st.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st          <= '0;
			st.pol      <= `SHP_POL_RST;
			st.pf_level <= `SHP_PF_LEVEL_RST;
			st.fc       <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign wb_dat_o           = st.dat;
	assign wb_ack_o           = st.ack;
	assign irq_o              = st.irq;
	assign link.status_flag_a = st.fa;
	assign link.status_flag_b = st.fb;
	assign link.status_flag_c = st.fc;
	assign link.status_flag_d = st.fd;
	assign link.flag_d_oe     = st.fd_oe;
	assign link.ready         = st.ready;
	assign link.dev_dq        = st.dq;
	assign link.dev_dq_oe     = st.dq_oe;
endmodule // shp_device_end

// *** logic/shp_host_end.sv ***
// external master end: runs one pin transfer per wishbone request
`timescale 1ns/10ps
`include "shp_cfg.svh"
module shp_host_end import shp_pkg::*; (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// link to the device
	shp_link_if.host         link
);
	shp_host_state_t st;
	shp_host_state_t next_st;

	logic [20:0] pin_s;

	////////////////////////////////////////////////////////////////////////////
	// device pins come from another chip
	shp_sync #(
		.W(21)
	) u_pin_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({link.status_flag_a, link.status_flag_b, link.status_flag_c,
			link.flag_cs_pin, link.ready, link.host_data_bus}),
		.q_o   (pin_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer and register slave
	always_comb begin
		logic req;
		logic busy;
		logic is_cmd;
		req     = wb_cyc_i & wb_stb_i;
		busy    = (st.state != SHP_H_IDLE);
		is_cmd  = (st.sel == `SHP_SEL_CMD);
		next_st = st;

		next_st.ack = req & ~st.ack;
		if (req & ~st.ack) begin
			case (wb_adr_i)
				`SHP_HOST_CTRL: begin
					next_st.dat = {22'h0, st.status_flag_d_mode, st.wide, st.pol};
				end
				`SHP_HOST_STATUS: begin
					next_st.dat = {st.rdat, 10'h0, pin_s[17], pin_s[18], pin_s[19],
						pin_s[20], pin_s[16], busy};
				end
				default: begin
					next_st.dat = 32'h0;
				end
			endcase
		end

		// new settings apply between transfers so pins never glitch mid-transfer
		if (req & st.ack & wb_we_i & ~busy & (wb_adr_i == `SHP_HOST_CTRL)) begin
			next_st.pol        = wb_dat_i[7:0];
			next_st.wide       = wb_dat_i[8];
			next_st.status_flag_d_mode = wb_dat_i[9];
		end
		// request: data [15:0], select [18:16], op [21:20]; ignored while busy
		if (req & st.ack & wb_we_i & ~busy & (wb_adr_i == `SHP_HOST_REQ)) begin
			next_st.op    = shp_op_t'(wb_dat_i[21:20]);
			next_st.sel   = wb_dat_i[18:16];
			next_st.cs_n  = st.status_flag_d_mode;
			next_st.dq    = st.wide ? wb_dat_i[15:0] : {8'h00, wb_dat_i[7:0]};
			next_st.dq_oe = {st.wide & (wb_dat_i[18:16] != `SHP_SEL_CMD), 1'b1};
			if (wb_dat_i[21:20] != 2'h0) begin
				next_st.dq_oe = 2'h0;
			end
			next_st.cnt   = `SHP_SETUP_CYC;
			next_st.state = SHP_H_SETUP;
		end

		case (st.state)
			SHP_H_IDLE: begin
				next_st.cs_oe = ~st.status_flag_d_mode;
			end
			SHP_H_SETUP: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else if (is_cmd & ~pin_s[16]) begin
					next_st.cnt = 4'h0;
				end else if (st.op == SHP_OP_READ) begin
					next_st.oe    = st.pol[`SHP_POL_OE];
					next_st.cnt   = `SHP_TURN_CYC;
					next_st.state = SHP_H_TURN;
				end else begin
					next_st.wr    = (st.op == SHP_OP_WRITE) ~^ st.pol[`SHP_POL_WR];
					next_st.pkt   = (st.op == SHP_OP_COMMIT) ~^ st.pol[`SHP_POL_PKT];
					next_st.cnt   = `SHP_STROBE_CYC;
					next_st.state = SHP_H_STROBE;
				end
			end
			SHP_H_TURN: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					// capture the head word, then pop it
					next_st.rdat  = (st.wide & ~is_cmd) ? pin_s[15:0] :
						{8'h00, pin_s[7:0]};
					next_st.rd    = st.pol[`SHP_POL_RD];
					next_st.cnt   = `SHP_STROBE_CYC;
					next_st.state = SHP_H_STROBE;
				end
			end
			SHP_H_STROBE: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					next_st.rd    = ~st.pol[`SHP_POL_RD];
					next_st.wr    = ~st.pol[`SHP_POL_WR];
					next_st.pkt   = ~st.pol[`SHP_POL_PKT];
					next_st.cnt   = `SHP_HOLD_CYC;
					next_st.state = SHP_H_HOLD;
				end
			end
			SHP_H_HOLD: begin
				if (st.cnt != 4'h0) begin
					next_st.cnt = st.cnt - 4'h1;
				end else begin
					next_st.oe    = ~st.pol[`SHP_POL_OE];
					next_st.dq_oe = 2'h0;
					next_st.cs_n  = 1'b1;
					next_st.state = SHP_H_IDLE;
				end
			end
			default: begin
				next_st.state = SHP_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st       <= '0;
			st.pol   <= `SHP_POL_RST;
			st.rd    <= 1'b1;
			st.wr    <= 1'b1;
			st.oe    <= 1'b1;
			st.pkt   <= 1'b1;
			st.cs_n  <= 1'b1;
			st.cs_oe <= 1'b1;
			st.state <= SHP_H_IDLE;
			st.op    <= SHP_OP_NONE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign wb_dat_o                  = st.dat;
	assign wb_ack_o                  = st.ack;
	assign link.fifo_select          = st.sel;
	assign link.fifo_read_strobe     = st.rd;
	assign link.fifo_write_strobe    = st.wr;
	assign link.fifo_output_enable   = st.oe;
	assign link.packet_commit_strobe = st.pkt;
	assign link.host_cs_n            = st.cs_n;
	assign link.host_cs_oe           = st.cs_oe;
	assign link.host_dq              = st.dq;
	assign link.host_dq_oe           = st.dq_oe;
endmodule // shp_host_end

// *** testbench/shp_link_properties.sv ***
// assertions on the pins between the master end and the fifo device end
`timescale 1ns/10ps
module shp_link_properties (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// master pins
	input wire logic [2:0] fifo_select,
	input wire logic       fifo_read_strobe,
	input wire logic       fifo_write_strobe,
	input wire logic       fifo_output_enable,
	input wire logic       packet_commit_strobe,
	input wire logic       host_cs_n,
	input wire logic       host_cs_oe,
	input wire logic [1:0] host_dq_oe,
	// device pins
	input wire logic       status_flag_a,
	input wire logic       status_flag_b,
	input wire logic       status_flag_c,
	input wire logic       flag_d_oe,
	input wire logic       ready,
	input wire logic [1:0] dev_dq_oe
);
	logic [6:0] pins;
	logic [6:0] prev;
	logic [3:0] quiet;
	logic [3:0] oe_age;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	assign pins = {fifo_select, fifo_read_strobe, fifo_write_strobe, packet_commit_strobe,
		fifo_output_enable};

	// cycles since pin activity; saturating so a long idle stretch never wraps
	always_ff @(posedge clk_i) begin
		prev <= pins;
		quiet <= (rst_i || pins != prev) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
		oe_age <= (rst_i || pins[0] != prev[0]) ? 4'h0 : oe_age + {3'h0, oe_age != 4'hf};
	end

	//////////////////////////////////////////////////////////////////////////////
	a_reset_idle: assert property ($fell(rst_i) |-> status_flag_c && !status_flag_b &&
		!status_flag_a && dev_dq_oe == 2'h0 && !flag_d_oe && !ready)
		else $error("pins not idle after reset");
	a_ready_rise: assert property ($fell(rst_i) |=> ready)
		else $error("ready did not rise after reset");
	a_no_contend: assert property ((dev_dq_oe & host_dq_oe) == 2'h0)
		else $error("both ends drive one byte lane");
	a_upper_alone: assert property (dev_dq_oe[1] |-> dev_dq_oe[0])
		else $error("upper byte driven without low byte");
	a_oe_latency: assert property ($changed(dev_dq_oe[0]) |-> oe_age <= 4'h5)
		else $error("bus drive changed without output enable");
	a_flag_excl: assert property (!(status_flag_b && status_flag_c))
		else $error("full and empty together");
	a_flags_settle: assert property (quiet >= 4'h8 |->
		$stable({status_flag_a, status_flag_b, status_flag_c}))
		else $error("flags moved with quiet pins");
	a_shared_pin: assert property (!(flag_d_oe && host_cs_oe))
		else $error("shared pin driven by both ends");
	a_strobe_cs: assert property (!(fifo_write_strobe && fifo_read_strobe) |->
		!host_cs_n || !host_cs_oe)
		else $error("strobe without chip select");

	// main scenarios reached
	c_read_drive: cover property ($rose(dev_dq_oe[0]));
	c_full: cover property ($rose(status_flag_b));
	c_flag_mode: cover property ($rose(flag_d_oe));
	c_cmd_busy: cover property ($fell(ready));
endmodule // shp_link_properties

// *** testbench/slave_fifo_host_port_pins_tb.sv ***
// self-checking bench: both ends joined pin to pin, each driven over wishbone
`timescale 1ns/10ps
`include "shp_cfg.svh"
module slave_fifo_host_port_pins_tb;
	typedef struct {
		string       nm;
		logic [31:0] ex;
		logic [31:0] m;
	} shp_note_t;
	logic        clk_i;
	logic        rst_i;
	logic        cyc [2];
	logic        stb [2];
	logic        wen [2];
	logic        chk [2];
	logic [7:0]  adr [2];
	logic [31:0] wdat [2];
	logic [31:0] rdo [2];
	logic        ack [2];
	logic        irq_o;
	logic [31:0] last;
	logic [15:0] d;
	int          seed;
	int          errors;
	int          num_checks;
	shp_note_t   notes [$];
	logic [15:0] model [4][$];

	shp_link_if shp_link_if_i ();
	shp_host_end shp_host_end_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc[0]),
		.wb_stb_i(stb[0]), .wb_we_i(wen[0]), .wb_adr_i(adr[0]), .wb_sel_i(4'hf),
		.wb_dat_i(wdat[0]), .wb_dat_o(rdo[0]), .wb_ack_o(ack[0]), .link(shp_link_if_i.host));
	shp_device_end shp_device_end_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc[1]),
		.wb_stb_i(stb[1]), .wb_we_i(wen[1]), .wb_adr_i(adr[1]), .wb_sel_i(4'hf),
		.wb_dat_i(wdat[1]), .wb_dat_o(rdo[1]), .wb_ack_o(ack[1]), .irq_o(irq_o),
		.link(shp_link_if_i.dev));
	shp_link_properties shp_link_properties_i (.clk_i(clk_i), .rst_i(rst_i),
		.fifo_select(shp_link_if_i.fifo_select),
		.fifo_read_strobe(shp_link_if_i.fifo_read_strobe),
		.fifo_write_strobe(shp_link_if_i.fifo_write_strobe),
		.fifo_output_enable(shp_link_if_i.fifo_output_enable),
		.packet_commit_strobe(shp_link_if_i.packet_commit_strobe),
		.host_cs_n(shp_link_if_i.host_cs_n), .host_cs_oe(shp_link_if_i.host_cs_oe),
		.host_dq_oe(shp_link_if_i.host_dq_oe), .status_flag_a(shp_link_if_i.status_flag_a),
		.status_flag_b(shp_link_if_i.status_flag_b),
		.status_flag_c(shp_link_if_i.status_flag_c), .flag_d_oe(shp_link_if_i.flag_d_oe),
		.ready(shp_link_if_i.ready), .dev_dq_oe(shp_link_if_i.dev_dq_oe));

	//////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] ex, m, got);
		num_checks++;
		if ((got & m) !== (ex & m)) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex & m, got & m);
		end
	endtask

	// one classic cycle; the answer time is not assumed, only bounded
	task automatic wb(input int e, input logic we, input logic [7:0] a,
		input logic [31:0] v, ex, m, input string nm);
		int n;
		if (m != 0)
			notes.push_back('{nm, ex, m});
		cyc[e] <= 1'b1;
		stb[e] <= 1'b1;
		wen[e] <= we;
		adr[e] <= a;
		wdat[e] <= v;
		chk[e] <= (m != 0);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack[e] !== 1'b1 && n < 50);
		last = rdo[e];
		if (n >= 50) begin
			errors++;
			tally_and_finish();
		end
		cyc[e] <= 1'b0;
		stb[e] <= 1'b0;
		chk[e] <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input int e, input logic [7:0] a, input logic [31:0] ex, m, input string nm);
		wb(e, 1'b0, a, 32'h0, ex, m, nm);
	endtask

	task automatic wr(input int e, input logic [7:0] a, input logic [31:0] v);
		wb(e, 1'b1, a, v, 32'h0, 32'h0, "");
	endtask

	// one pin transfer by the master end, then let the flags cross
	task automatic host_op(input logic [2:0] s, input logic [1:0] op, input logic [15:0] v);
		int n;
		wr(0, `SHP_HOST_REQ, {10'h000, op, 1'b0, s, v});
		n = 0;
		do begin
			wb(0, 1'b0, `SHP_HOST_STATUS, 32'h0, 32'h0, 32'h0, "");
			n++;
		end while (last[0] !== 1'b0 && n < 60);
		if (n >= 60) begin
			errors++;
			tally_and_finish();
		end
		repeat (8) @(posedge clk_i);
	endtask

	// read results are checked as they appear, oldest note first
	always @(posedge clk_i) begin
		for (int e = 0; e < 2; e++) begin
			if (chk[e] === 1'b1 && ack[e] === 1'b1 && notes.size() > 0) begin
				cmp(notes[0].nm, notes[0].ex, notes[0].m, rdo[e]);
				void'(notes.pop_front());
			end
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// a hang anywhere ends the run as a failure
	initial begin
		repeat (100000) @(posedge clk_i);
		errors++;
		tally_and_finish();
	end

	initial begin
		seed = 92425;
		errors = 0;
		num_checks = 0;
		rst_i = 1'b1;
		for (int e = 0; e < 2; e++) begin
			cyc[e] = 1'b0;
			stb[e] = 1'b0;
			wen[e] = 1'b0;
			chk[e] = 1'b0;
			adr[e] = 8'h00;
			wdat[e] = 32'h0;
		end
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(1, `SHP_DEV_CTRL, 32'h4000, 32'hffff, "dev ctrl");
		rd(0, `SHP_HOST_STATUS, 32'h32, 32'h3f, "host status");
		$display("test reset done");
		// 16-bit mode: four words into every fifo, then one fifo to full and over
		wr(0, `SHP_HOST_CTRL, 32'h100);
		wr(1, `SHP_DEV_CTRL, 32'h4200);
		wr(1, `SHP_DEV_IRQ_MASK, 32'h7);
		for (int k = 0; k < 20; k++) begin
			d = 16'($random(seed));
			host_op(3'(k < 16 ? k / 4 : 2), 2'h0, d);
			model[k < 16 ? k / 4 : 2].push_back(d);
			if (k == 15)
				rd(0, `SHP_HOST_STATUS, 32'h04, 32'h1c, "level flags");
		end
		rd(0, `SHP_HOST_STATUS, 32'h0c, 32'h1c, "full flags");
		host_op(3'h2, 2'h0, 16'hffff);
		rd(1, `SHP_DEV_IRQ_ST, 32'h4, 32'h4, "overflow");
		cmp("irq", 32'h1, 32'h1, {31'h0, irq_o});
		wr(1, `SHP_DEV_IRQ_ST, 32'h7);
		repeat (2) @(posedge clk_i);
		cmp("irq", 32'h0, 32'h1, {31'h0, irq_o});
		for (int f = 0; f < 4; f++) begin
			while (model[f].size() > 0) begin
				host_op(3'(f), 2'h1, 16'h0);
				rd(0, `SHP_HOST_STATUS, {model[f].pop_front(), 16'h0}, 32'hffff0000, "fifo data");
			end
		end
		rd(0, `SHP_HOST_STATUS, 32'h10, 32'h1c, "empty flags");
		$display("test wide fifo done");
		// 8-bit mode carries the low byte only
		wr(0, `SHP_HOST_CTRL, 32'h0);
		wr(1, `SHP_DEV_CTRL, 32'h4000);
		host_op(3'h3, 2'h0, 16'habcd);
		host_op(3'h3, 2'h1, 16'h0);
		rd(0, `SHP_HOST_STATUS, 32'h00cd0000, 32'h00ff0000, "narrow data");
		// command slot both ways; ready stays low until the slot is read
		host_op(3'h4, 2'h0, 16'h005a);
		rd(0, `SHP_HOST_STATUS, 32'h0, 32'h2, "ready busy");
		rd(1, `SHP_DEV_CMD, 32'h15a, 32'h1ff, "command in");
		wr(1, `SHP_DEV_CMD, 32'hc3);
		host_op(3'h4, 2'h1, 16'h0);
		rd(0, `SHP_HOST_STATUS, 32'h00c30002, 32'h00ff0002, "command out");
		$display("test command done");
		// packet commit on every fifo
		for (int f = 0; f < 4; f++) begin
			host_op(3'(f), 2'h2, 16'h0);
			rd(1, `SHP_DEV_LEVELS, 32'(f) << 16, 32'h70000, "commit fifo");
			rd(1, `SHP_DEV_IRQ_ST, 32'h2, 32'h2, "commit irq");
			wr(1, `SHP_DEV_IRQ_ST, 32'h7);
		end
		$display("test commit done");
		// shared pin as level flag of fifo 2; let the new flag cross first
		wr(0, `SHP_HOST_CTRL, 32'h200);
		wr(1, `SHP_DEV_CTRL, 32'h4900);
		repeat (4) @(posedge clk_i);
		rd(0, `SHP_HOST_STATUS, 32'h0, 32'h20, "flag d low");
		for (int k = 0; k < 4; k++)
			host_op(3'h2, 2'h0, 16'($random(seed)));
		rd(0, `SHP_HOST_STATUS, 32'h20, 32'h20, "flag d high");
		$display("test flag mode done");
		tally_and_finish();
	end
endmodule // slave_fifo_host_port_pins_tb
